// ==== verilog/psim_status_irq.v ====
/*
 Status flags, mask registers and the active-low interrupt pin of the
 PMIC status block, with internal acknowledge tracking.
 Assumes a serial interface engine in front of it giving one-cycle read
 and write strobes with an 8-bit register address, and analog
 comparators and charger timers giving levels on the same clock.
*/
`timescale 1ns/1ps
`include "psim_regs.vh"

module psim_status_irq #(
   parameter [35:0] TAPER_TIMEOUT_CYC = `PSIM_TAPER_TIME_S * `PSIM_CLOCK_HZ
) (
   input  wire       i_clock,
   input  wire       i_resetn,
   input  wire       i_wait_all_rails_off,
   input  wire [7:0] i_reg_addr,
   input  wire       i_reg_wr,
   input  wire [7:0] i_reg_wdata,
   input  wire       i_reg_rd,
   output reg  [7:0] o_reg_rdata,
   input  wire       i_timer_enable,
   input  wire       i_taper_cmp,
   input  wire       i_chg_timer_expired,
   input  wire       i_prechg_timer_expired,
   input  wire       i_battery_temp_fault,
   input  wire [3:0] i_charger_upper_flags,
   input  wire       i_power_button_request,
   input  wire       i_battery_cover_input,
   input  wire       i_supply_undervoltage,
   input  wire       i_ldo_b_out_of_reg,
   input  wire       i_ldo_b_enable,
   input  wire       i_ldo_a_out_of_reg,
   input  wire       i_ldo_a_enable,
   input  wire       i_main_buck_out_of_reg,
   input  wire       i_core_buck_out_of_reg,
   input  wire       i_core_low_power_bit,
   input  wire       i_low_power_mode,
   output wire       o_int_n
);

   // Rail power-down in wait mode acts like a reset
   wire        clear = !i_resetn || i_wait_all_rails_off;

   // One decode shared by the write and acknowledge strobe and address pairs; read data uses its own case
   function hit;
      input       strobe;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         hit = strobe && (addr == ofs);
      end
   endfunction

   reg  [7:0]  rail_raw;
   reg  [7:0]  rail_meta_ff;
   reg  [7:0]  rail_status_flags_ff;
   reg  [7:0]  rail_prev_ff;
   reg  [6:0]  chg_meta_ff;
   reg  [6:0]  chg_sync_ff;
   reg  [7:0]  charge_status_flags;
   reg  [2:0]  chg_tmo_ff;
   reg  [35:0] taper_cnt_ff;
   reg  [7:0]  charge_irq_mask_ff;
   reg  [7:0]  rail_irq_mask_ff;
   reg  [7:0]  charge_irq_ack_ff;
   reg  [7:0]  rail_irq_ack_ff;
   reg  [7:0]  rail_event_ff;
   reg  [7:0]  nxt_rail_event;
   reg  [7:0]  nxt_rdata;
   wire [7:0]  rail_rise;
   wire        taper_expire;
   wire        wr_chg  = hit(i_reg_wr, i_reg_addr, `PSIM_OFS_CHG_STATUS);
   wire        rd_chg  = hit(i_reg_rd, i_reg_addr, `PSIM_OFS_CHG_STATUS);
   wire        rd_rail = hit(i_reg_rd, i_reg_addr, `PSIM_OFS_RAIL_STATUS);

   // Raw rail conditions before synchronisation
   always @* begin
      rail_raw = 8'h00;
      rail_raw[`PSIM_BIT_BUTTON] = i_power_button_request;
      rail_raw[`PSIM_BIT_COVER]  = !i_battery_cover_input;
      rail_raw[`PSIM_BIT_SUPPLY_UNDERVOLTAGE_FLAG]   = i_supply_undervoltage;
      rail_raw[`PSIM_BIT_LDO_B]  = i_ldo_b_out_of_reg
                                   && i_ldo_b_enable;
      rail_raw[`PSIM_BIT_LDO_A]  = i_ldo_a_out_of_reg
                                   && i_ldo_a_enable;
      rail_raw[`PSIM_BIT_MAIN]   = i_main_buck_out_of_reg;
      rail_raw[`PSIM_BIT_CORE]   = i_core_buck_out_of_reg
         || (i_core_low_power_bit && i_low_power_mode);
   end

   // Two stages; the register itself is the second stage
   always @(posedge i_clock) begin
      if (clear) begin
         rail_meta_ff         <= `PSIM_RST_STATUS;
         rail_status_flags_ff <= `PSIM_RST_STATUS;
         rail_prev_ff         <= `PSIM_RST_STATUS;
         chg_meta_ff          <= 7'h00;
         chg_sync_ff          <= 7'h00;
      end else begin
         rail_meta_ff         <= rail_raw;
         rail_status_flags_ff <= rail_meta_ff;
         rail_prev_ff         <= rail_status_flags_ff;
         chg_meta_ff <= {i_charger_upper_flags, i_taper_cmp,
                         i_battery_temp_fault, i_chg_timer_expired ^ 1'b0};
         chg_sync_ff <= chg_meta_ff;
      end
   end

   // Edge taken against the previous status, never the first stage
   assign rail_rise = rail_status_flags_ff & ~rail_prev_ff;

   // Taper delay only counts while comparator is high
   // A comparator dip restarts the full delay; no partial credit is kept
   assign taper_expire = (taper_cnt_ff == TAPER_TIMEOUT_CYC - 36'h0_0000_0001);

   always @(posedge i_clock) begin
      if (clear || !i_timer_enable || !chg_sync_ff[2]) begin
         taper_cnt_ff <= 36'h0_0000_0000;
      end else if (!taper_expire) begin
         taper_cnt_ff <= taper_cnt_ff + 36'h0_0000_0001;
      end
   end

   // Timeout flags: hardware set wins over a host write
   always @(posedge i_clock) begin
      if (clear) begin
         chg_tmo_ff <= 3'b000;
      end else begin
         if (wr_chg) begin
            chg_tmo_ff <= i_reg_wdata[`PSIM_BIT_TAPER:`PSIM_BIT_PRECHG];
         end
         if (i_prechg_timer_expired) begin
            chg_tmo_ff[0] <= 1'b1;
         end
         if (chg_sync_ff[0]) begin
            chg_tmo_ff[1] <= 1'b1;
         end
         if (i_timer_enable && taper_expire) begin
            chg_tmo_ff[2] <= 1'b1;
         end
      end
   end

   // Bits 0 and 7..4 are never stored, so writes there vanish
   always @* begin
      charge_status_flags = {chg_sync_ff[6:3], chg_tmo_ff,
                             chg_sync_ff[1]};
      if (!i_timer_enable) begin
         charge_status_flags[`PSIM_BIT_TAPER] = chg_sync_ff[2];
      end
   end

   always @(posedge i_clock) begin
      if (clear) begin
         charge_irq_mask_ff <= `PSIM_RST_MASK;
         rail_irq_mask_ff   <= `PSIM_RST_MASK;
      end else begin
         if (hit(i_reg_wr, i_reg_addr, `PSIM_OFS_CHG_MASK)) begin
            charge_irq_mask_ff <= i_reg_wdata;
         end
         if (hit(i_reg_wr, i_reg_addr, `PSIM_OFS_RAIL_MASK)) begin
            rail_irq_mask_ff <= i_reg_wdata;
         end
      end
   end

   // Reading a status register acknowledges what it shows, except a rail bit rising in that same cycle
   always @* begin
      nxt_rail_event = (rail_event_ff & rail_status_flags_ff)
                       & ~({8{rd_rail}} & rail_status_flags_ff);
      nxt_rail_event = nxt_rail_event | rail_rise;
   end

   always @(posedge i_clock) begin
      if (clear) begin
         charge_irq_ack_ff <= `PSIM_RST_ACK;
         rail_irq_ack_ff   <= `PSIM_RST_ACK;
         rail_event_ff     <= `PSIM_RST_STATUS;
      end else begin
         // Ack drops as soon as the condition goes away
         charge_irq_ack_ff <= (charge_irq_ack_ff
            | ({8{rd_chg}} & charge_status_flags))
            & charge_status_flags;
         rail_irq_ack_ff <= (rail_irq_ack_ff | ({8{rd_rail}}
            & rail_status_flags_ff)) & rail_status_flags_ff
            & ~rail_rise;
         rail_event_ff <= nxt_rail_event;
      end
   end

   // Pin low while any unmasked, unacknowledged source is pending
   assign o_int_n = !(|(charge_status_flags & ~charge_irq_mask_ff
                        & ~charge_irq_ack_ff)
                     || |(rail_event_ff & ~rail_irq_mask_ff));

   // Unmapped addresses read as zero rather than floating
   always @* begin
      case (i_reg_addr)
         `PSIM_OFS_CHG_STATUS:  nxt_rdata = charge_status_flags;
         `PSIM_OFS_RAIL_STATUS: nxt_rdata = rail_status_flags_ff;
         `PSIM_OFS_CHG_MASK:    nxt_rdata = charge_irq_mask_ff;
         `PSIM_OFS_RAIL_MASK:   nxt_rdata = rail_irq_mask_ff;
         `PSIM_OFS_CHG_ACK:     nxt_rdata = charge_irq_ack_ff;
         `PSIM_OFS_RAIL_ACK:    nxt_rdata = rail_irq_ack_ff;
         default:               nxt_rdata = 8'h00;
      endcase
   end

   always @(posedge i_clock) begin
      if (clear) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         o_reg_rdata <= nxt_rdata;
      end
   end

endmodule

// ==== verilog/psim_regs.vh ====
/*
 Register map, field positions, reset values and timing counts of the
 PMIC status and interrupt mask block.
 Assumes the serial interface engine presents decoded register
 accesses one clock wide at the 25 MHz internal clock.
*/
// Function
// - Taper flag: comparator, or after 30 minutes
// - Timeout flags bits 3..1 reset 0, read/write
// - Bit 0 shows battery temperature fault
// - Rail bit rising edge pulls interrupt low
// - Rail bit 7 shows power button request
// - Rail bit 6 is inverted cover pin
// - Rail bit 5 shows supply undervoltage
// - Rail bit 3: LDO B fault if enabled
// - Rail bit 2: LDO A fault if enabled
// - Rail bit 1 shows main buck fault
// - Rail bit 0: core fault or low power
// - Charge mask resets all ones, blocks flags
// - Rail mask resets all ones, blocks flags
// - Charge flags interrupt; writes to 0,4-7 ignored
// - Acknowledged flag releases pin until condition clears
// - Wait mode, rails off: registers to default
`ifndef PSIM_REGS_VH
`define PSIM_REGS_VH

`define PSIM_OFS_CHG_STATUS  8'h01
`define PSIM_OFS_RAIL_STATUS 8'h02
`define PSIM_OFS_CHG_MASK    8'h03
`define PSIM_OFS_RAIL_MASK   8'h04
`define PSIM_OFS_CHG_ACK     8'h05
`define PSIM_OFS_RAIL_ACK    8'h06

`define PSIM_RST_STATUS      8'h00
`define PSIM_RST_MASK        8'hFF
`define PSIM_RST_ACK         8'h00

`define PSIM_BIT_TEMP        0
`define PSIM_BIT_PRECHG      1
`define PSIM_BIT_CHG         2
`define PSIM_BIT_TAPER       3
`define PSIM_CHG_WR_BITS     8'h0E

`define PSIM_BIT_CORE        0
`define PSIM_BIT_MAIN        1
`define PSIM_BIT_LDO_A       2
`define PSIM_BIT_LDO_B       3
`define PSIM_BIT_RAIL_RSVD   4
`define PSIM_BIT_SUPPLY_UNDERVOLTAGE_FLAG        5
`define PSIM_BIT_COVER       6
`define PSIM_BIT_BUTTON      7

// Taper delay in seconds and clock rate in hertz
`define PSIM_TAPER_TIME_S    36'h0_0000_0708
`define PSIM_CLOCK_HZ        36'h0_017D_7840

`endif

// ==== testbench/psim_src_model.sv ====
/* Comparator and pin model feeding the status block; bench sets i_ctl. */
`timescale 1ns/1ps
module psim_src_model (
   input  wire [7:0] i_ctl,
   output wire [7:0] o_src
);
   assign o_src = i_ctl ^ 8'h40;
endmodule

// ==== testbench/psim_status_irq_props.sv ====
/* Port assertions for the status block; one clock, synchronous reset. */
`timescale 1ns/1ps
module psim_status_irq_props (
   input wire       i_clock,
   input wire       i_resetn,
   input wire       i_wait_all_rails_off,
   input wire [7:0] i_reg_addr,
   input wire       i_reg_wr,
   input wire [7:0] i_reg_wdata,
   input wire       i_reg_rd,
   input wire [7:0] o_reg_rdata,
   input wire       i_main_buck_out_of_reg,
   input wire       o_int_n
);
   reg  [7:0] cm_ff, rm_ff;
   wire       clr = !i_resetn || i_wait_all_rails_off;
   wire       wm = i_reg_wr && !clr;
   wire [7:0] ra = i_reg_rd ? i_reg_addr : 8'h00;
   // Shadow masks predict the pin from the ports alone
   always @(posedge i_clock) begin
      cm_ff <= clr ? 8'hFF : (wm && i_reg_addr == 8'h03) ? i_reg_wdata : cm_ff;
      rm_ff <= clr ? 8'hFF : (wm && i_reg_addr == 8'h04) ? i_reg_wdata : rm_ff;
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   quiet_a: assert property ($fell(clr) |-> o_int_n)
      else $error("pin low after reset");
   rd_idle_a: assert property ($fell(clr) |-> ~|o_reg_rdata)
      else $error("read data not cleared by reset");
   mask_all_a: assert property (&cm_ff && &rm_ff |-> o_int_n)
      else $error("pin low with all sources masked");
   ack_free_a: assert property (ra == 8'h02 && &cm_ff |=> o_int_n)
      else $error("pin still low after status read");
   rmask_rd_a: assert property (ra == 8'h04
      |=> o_reg_rdata == $past(rm_ff)) else $error("rail mask read wrong");
   cmask_rd_a: assert property (ra == 8'h03
      |=> o_reg_rdata == $past(cm_ff)) else $error("charge mask read wrong");
   rd_hold_a: assert property (!i_reg_rd && !clr |=> $stable(o_reg_rdata))
      else $error("read data changed without a read");
   rail_rise_a: assert property ($rose(i_main_buck_out_of_reg) && !rm_ff[1]
      && !ra ##1 (!ra && !clr) [*3] |-> !o_int_n) else $error("rise missed");
endmodule
bind psim_status_irq psim_status_irq_props i_props (.*);

// ==== testbench/psim_status_irq_bench.sv ====
/* Bench for the status block: register access, sources, pin checks. */
`timescale 1ns/1ps
module psim_status_irq_bench;
   reg        clk = 1'b0, resetn = 1'b0, wait_off = 1'b0, wr = 1'b0, rd = 1'b0;
   reg  [7:0] addr = 8'h00, wdata = 8'h00, ctl = 8'h00, cfg = 8'h00;
   wire [7:0] rdata, s;
   wire       int_n;
   integer    n_fail = 0, n_compared = 0, i;
   always #20 clk = ~clk;
   psim_src_model i_src (.i_ctl(ctl), .o_src(s));
   psim_status_irq #(.TAPER_TIMEOUT_CYC(36'h0_0000_0014)) i_dut (
      .i_clock(clk), .i_resetn(resetn), .i_wait_all_rails_off(wait_off),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd),
      .o_reg_rdata(rdata), .i_timer_enable(cfg[0]), .i_taper_cmp(cfg[1]),
      .i_chg_timer_expired(cfg[2]), .i_prechg_timer_expired(cfg[3]),
      .i_battery_temp_fault(s[4]), .i_charger_upper_flags(4'h0),
      .i_power_button_request(s[7]), .i_battery_cover_input(s[6]),
      .i_supply_undervoltage(s[5]), .i_ldo_b_out_of_reg(s[3]),
      .i_ldo_b_enable(cfg[5]), .i_ldo_a_out_of_reg(s[2]),
      .i_ldo_a_enable(cfg[4]), .i_main_buck_out_of_reg(s[1]),
      .i_core_buck_out_of_reg(s[0]), .i_core_low_power_bit(cfg[6]),
      .i_low_power_mode(cfg[7]), .o_int_n(int_n));
   task chk(input [7:0] got, input [7:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Write when w is set, else read and compare against d
   task acc(input w, input [7:0] a, input [7:0] d);
      @(negedge clk);
      {addr, wdata, wr, rd} = {a, d, w, !w};
      @(negedge clk);
      {wr, rd} = 2'b00;
      if (!w) chk(rdata, d);
   endtask
   // Four cycles cover the two-stage synchroniser with margin
   task src(input [7:0] c, input [7:0] f);
      ctl = c;
      cfg = f;
      repeat (4) @(negedge clk);
   endtask
   task test_done;
      if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      acc(0, 8'h04, 8'hFF);
      acc(1, 8'h04, 8'hA5);
      acc(0, 8'h04, 8'hA5);
      src(8'h00, 8'h31);
      acc(1, 8'h01, 8'hFF);
      acc(0, 8'h01, 8'h0E);
      acc(1, 8'h01, 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
         src(8'h01 << i, 8'h31);
         chk({7'h00, int_n}, (8'hB5 >> i) & 8'h01);
         acc(0, 8'h02, i == 4 ? 8'h00 : ctl);
      end
      src(8'h0C, 8'hC1);
      acc(0, 8'h02, 8'h01);
      acc(1, 8'h04, 8'hFD);
      src(8'h02, 8'h01);
      chk({7'h00, int_n}, 8'h00);
      acc(0, 8'h02, 8'h02);
      acc(0, 8'h06, 8'h02);
      chk({7'h00, int_n}, 8'h01);
      src(8'h10, 8'h01);
      acc(0, 8'h06, 8'h00);
      acc(1, 8'h03, 8'hFE);
      chk({7'h00, int_n}, 8'h00);
      acc(0, 8'h01, 8'h01);
      src(8'h00, 8'h03);
      acc(0, 8'h01, 8'h00);
      repeat (40) @(negedge clk);
      acc(0, 8'h01, 8'h08);
      src(8'h00, 8'h00);
      acc(0, 8'h01, 8'h00);
      wait_off = 1'b1;
      src(8'h00, 8'h00);
      wait_off = 1'b0;
      acc(0, 8'h03, 8'hFF);
      test_done;
   end
   // Tests take about 160 cycles; this bound is far beyond that
   initial begin
      #200000 n_fail = n_fail + 1;
      test_done;
   end
endmodule
